/* rtl/fmhp_port.sv */
// fmhp_port: host parallel bus port of the fax modem interface memory
`timescale 1ns/10ps

module fmhp_port (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic bus_style_strap_i,
  input wire logic cs_n_i,
  input wire logic read_phase_i,
  input wire logic write_dir_i,
  input wire logic [4:0] register_select_lines_i,
  input wire logic [7:0] host_data_lines_i,
  output logic [7:0] host_data_lines_o,
  output logic [7:0] host_data_lines_oe_o,
  input wire logic irq_event_i,
  output logic irq_n_o,
  output logic irq_n_oe_o,
  output logic [7:0] status_o
);

  // ----------------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------------
  localparam int PW = 2 + 1 + 1 + 5 + 8;
  logic [PW-1:0] raw;
  logic [PW-1:0] synced;
  logic strap_s;
  fmhp_pkg::fmhp_pins_t pins;

  // strobe style inputs are active low on the pins; phase style high
  assign raw = {bus_style_strap_i, ~cs_n_i, read_phase_i, write_dir_i,
                register_select_lines_i, host_data_lines_i};

  fmhp_sync #(
    .W(PW)
  ) u_sync (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .d_i(raw[PW-1:0]),
    .q_o(synced)
  );

  assign strap_s = synced[PW-1];
  assign pins = synced[PW-2:0];

  // ----------------------------------------------------------------------
  // strap capture
  // ----------------------------------------------------------------------
  // strap is taken after reset release and then held; changing it live
  // would flip strobe meaning mid-access
  logic style_phase;
  logic style_valid;
  logic [2:0] settle;
  logic next_style_phase;
  logic next_style_valid;
  logic [2:0] next_settle;

  // the synchroniser restarts from zero at reset; wait for it to refill
  always_comb begin
    next_style_phase = style_phase;
    next_style_valid = style_valid;
    next_settle = settle;
    if (!style_valid) begin
      if (settle == 3'(fmhp_pkg::STRAP_SETTLE)) begin
        next_style_phase = strap_s;
        next_style_valid = 1'b1;
      end else begin
        next_settle = settle + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      style_phase <= 1'b0;
      style_valid <= 1'b0;
      settle <= 3'h0;
    end else begin
      style_phase <= next_style_phase;
      style_valid <= next_style_valid;
      settle <= next_settle;
    end
  end

  // ----------------------------------------------------------------------
  // strobe decode
  // ----------------------------------------------------------------------
  logic rd_act;
  logic wr_act;
  logic wr_dir_s;

  always_comb begin
    if (style_phase) begin
      // phase clock high frames the access, direction line picks it
      rd_act = pins.sel && pins.rd_phase && pins.wr_dir;
      wr_act = pins.sel && pins.rd_phase && !pins.wr_dir;
    end else begin
      // pins are active low: low level means strobe asserted
      rd_act = pins.sel && !pins.rd_phase;
      wr_act = pins.sel && !pins.wr_dir;
    end
    wr_dir_s = wr_act;
  end

  // ----------------------------------------------------------------------
  // transfer sequencer
  // ----------------------------------------------------------------------
  fmhp_pkg::fmhp_state_t state;
  fmhp_pkg::fmhp_state_t next_state;
  logic [4:0] addr;
  logic [4:0] next_addr;
  logic [7:0] wdata;
  logic [7:0] next_wdata;
  logic commit;

  always_comb begin
    next_state = state;
    next_addr = addr;
    next_wdata = wdata;
    commit = 1'b0;
    case (state)
      fmhp_pkg::FMHP_IDLE: begin
        if (rd_act && style_valid) begin
          next_state = fmhp_pkg::FMHP_READ;
          next_addr = pins.addr;
        end else if (wr_dir_s && style_valid) begin
          next_state = fmhp_pkg::FMHP_WRITE;
          next_addr = pins.addr;
        end
      end
      fmhp_pkg::FMHP_READ: begin
        next_addr = pins.addr;
        if (!rd_act) begin
          next_state = fmhp_pkg::FMHP_IDLE;
        end
      end
      fmhp_pkg::FMHP_WRITE: begin
        // keep latest address and data; commit at trailing edge
        if (wr_act) begin
          next_addr = pins.addr;
          next_wdata = pins.data;
        end else begin
          commit = 1'b1;
          next_state = fmhp_pkg::FMHP_DONE;
        end
      end
      fmhp_pkg::FMHP_DONE: begin
        next_state = fmhp_pkg::FMHP_IDLE;
      end
      default: begin
        next_state = fmhp_pkg::FMHP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state <= fmhp_pkg::FMHP_IDLE;
      addr <= 5'h00;
      wdata <= fmhp_pkg::DATA_RST;
    end else begin
      state <= next_state;
      addr <= next_addr;
      wdata <= next_wdata;
    end
  end

  // ----------------------------------------------------------------------
  // interface memory
  // ----------------------------------------------------------------------
  // stand-in for the modem core's registers; register 0 carries the
  // interrupt enable in bit 0 and reads back the pending flag in bit 7
  logic [7:0] mem [fmhp_pkg::NUM_REGS];
  logic [7:0] next_mem [fmhp_pkg::NUM_REGS];
  fmhp_pkg::fmhp_wreq_t wreq;
  logic irq_pend;
  logic next_irq_pend;
  logic clr_pend;

  always_comb begin
    wreq.wr = commit;
    wreq.addr = addr;
    wreq.data = wdata;
    for (int i = 0; i < fmhp_pkg::NUM_REGS; i++) begin
      next_mem[i] = mem[i];
    end
    if (wreq.wr) begin
      next_mem[wreq.addr] = wreq.data;
    end
    clr_pend = wreq.wr && (wreq.addr == 5'h00) && wreq.data[7];
    next_irq_pend = irq_pend;
    if (clr_pend) begin
      next_irq_pend = 1'b0;
    end
    // a new event in the clearing cycle wins
    if (irq_event_i && mem[0][0]) begin
      next_irq_pend = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      for (int i = 0; i < fmhp_pkg::NUM_REGS; i++) begin
        mem[i] <= fmhp_pkg::REG_RST;
      end
      irq_pend <= 1'b0;
    end else begin
      for (int i = 0; i < fmhp_pkg::NUM_REGS; i++) begin
        mem[i] <= next_mem[i];
      end
      irq_pend <= next_irq_pend;
    end
  end

  // ----------------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------------
  logic [7:0] dout;
  logic [7:0] doe;
  logic [7:0] next_dout;
  logic [7:0] next_doe;
  logic irq_oe;
  logic [7:0] stat;
  logic [7:0] next_stat;

  always_comb begin
    next_dout = fmhp_pkg::DATA_RST;
    next_doe = 8'h00;
    if (next_state == fmhp_pkg::FMHP_READ) begin
      next_dout = (next_addr == 5'h00) ?
                  {irq_pend, mem[0][6:0]} : mem[next_addr];
      next_doe = 8'hFF;
    end
    next_stat = mem[1];
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      dout <= fmhp_pkg::DATA_RST;
      doe <= 8'h00;
      irq_oe <= 1'b0;
      stat <= fmhp_pkg::REG_RST;
    end else begin
      dout <= next_dout;
      doe <= next_doe;
      irq_oe <= next_irq_pend;
      stat <= next_stat;
    end
  end

  assign host_data_lines_o = dout;
  assign host_data_lines_oe_o = doe;
  assign irq_n_o = 1'b0;
  assign irq_n_oe_o = irq_oe;
  assign status_o = stat;

endmodule

/* rtl/fmhp_pkg.sv */
// fmhp_pkg: shared constants and carriers for the fax modem host bus port
package fmhp_pkg;

  // ----------------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam int NUM_REGS = 32;
  localparam int SYNC_STAGES = 3;
  // cycles after reset before the synchronised strap is trusted
  localparam int STRAP_SETTLE = 5;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  // host pins after synchronisation; select is active high here, rd_phase and wr_dir keep their pin polarity
  typedef struct packed {
    logic sel;
    logic rd_phase;
    logic wr_dir;
    logic [4:0] addr;
    logic [7:0] data;
  } fmhp_pins_t;

  // request handed to the modem core's interface memory
  typedef struct packed {
    logic wr;
    logic [4:0] addr;
    logic [7:0] data;
  } fmhp_wreq_t;

  // transfer sequencer states
  typedef enum logic [3:0] {
    FMHP_IDLE = 4'h1,
    FMHP_READ = 4'h2,
    FMHP_WRITE = 4'h4,
    FMHP_DONE = 4'h8
  } fmhp_state_t;

endpackage

/* rtl/fmhp_sync.sv */
// fmhp_sync: three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps

module fmhp_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] q;
  logic [W-1:0] next_q;

  // s1 feeds s2 only; output moves once s2 and s3 agree
  always_comb begin
    next_q = q;
    for (int i = 0; i < W; i++) begin
      if (s2[i] == s3[i]) begin
        next_q[i] = s3[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      q <= '0;
    end else begin
      s1 <= d_i;
      s2 <= s1;
      s3 <= s2;
      q <= next_q;
    end
  end

  assign q_o = q;

endmodule

/* tb/fmhp_host.sv */
// fmhp_host: host side of the shared data bus
`timescale 1ns/10ps
module fmhp_host (
  input wire logic clk_i,
  input wire logic drv_i,
  input wire logic [7:0] d_i,
  input wire logic [7:0] oe_i,
  input wire logic [7:0] q_i,
  output logic [7:0] bus_o
);
  logic [7:0] last = 8'h00;
  // undriven bits flip each cycle so a stale value cannot look valid
  always_comb begin
    bus_o = (oe_i & q_i) | (~oe_i & (drv_i ? d_i : ~last));
  end
  always_ff @(posedge clk_i) begin
    last <= bus_o;
  end
endmodule

/* tb/fmhp_port_chk.sv */
// fmhp_port_chk: pin-level assertions for the host bus port
`timescale 1ns/10ps
module fmhp_port_chk (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic bus_style_strap_i,
  input wire logic cs_n_i,
  input wire logic read_phase_i,
  input wire logic write_dir_i,
  input wire logic [4:0] register_select_lines_i,
  input wire logic [7:0] host_data_lines_i,
  input wire logic [7:0] host_data_lines_o,
  input wire logic [7:0] host_data_lines_oe_o,
  input wire logic irq_event_i,
  input wire logic irq_n_o,
  input wire logic irq_n_oe_o,
  input wire logic [7:0] status_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  a_oe_whole_byte: assert property (
    host_data_lines_oe_o inside {8'h00, 8'hFF}) else $error("oe split");
  a_irq_level_low: assert property (
    irq_n_o == 1'b0) else $error("irq level");
  a_oe_needs_cs: assert property (
    $rose(host_data_lines_oe_o[0]) |-> $past(!cs_n_i, 3))
    else $error("drive without select");
  a_idle_release: assert property (
    cs_n_i [*8] |-> host_data_lines_oe_o == 8'h00)
    else $error("drive while idle");
  a_write_no_drive: assert property (
    (!bus_style_strap_i && !write_dir_i && read_phase_i) [*8]
    |-> host_data_lines_oe_o == 8'h00) else $error("drive on write");
  a_phase_wr_quiet: assert property (
    (bus_style_strap_i && !write_dir_i) [*8]
    |-> host_data_lines_oe_o == 8'h00) else $error("drive on rnw low");
  a_strobe_read: assert property (
    (!bus_style_strap_i && !cs_n_i && !read_phase_i && write_dir_i) [*7]
    |-> host_data_lines_oe_o == 8'hFF) else $error("strobe read idle");
  a_phase_read: assert property (
    (bus_style_strap_i && !cs_n_i && read_phase_i && write_dir_i) [*7]
    |-> host_data_lines_oe_o == 8'hFF) else $error("phase read idle");
  a_irq_cause: assert property (
    $rose(irq_n_oe_o) |-> $past(irq_event_i))
    else $error("irq without event");
endmodule
bind fmhp_port fmhp_port_chk u_chk (.*);

/* tb/tb.sv */
// tb: self-checking bench for the host bus port in both bus styles
`timescale 1ns/10ps
module tb;
  logic clk_i = 0, srst_i = 1, strap = 0, cs_n = 1, rp = 1, wd = 1;
  logic ev = 0, hdrv = 0, irq_n, irq_oe;
  logic [4:0] adr = 0;
  logic [7:0] hd = 0, bus, dq, doe, st, q;
  logic [7:0] exp_mem [32];
  int err_count = 0, checks = 0;
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  fmhp_port u_dut (.clk_i(clk_i), .srst_i(srst_i),
    .bus_style_strap_i(strap), .cs_n_i(cs_n), .read_phase_i(rp),
    .write_dir_i(wd), .register_select_lines_i(adr),
    .host_data_lines_i(bus), .host_data_lines_o(dq),
    .host_data_lines_oe_o(doe), .irq_event_i(ev), .irq_n_o(irq_n),
    .irq_n_oe_o(irq_oe), .status_o(st));
  fmhp_host u_host (.clk_i(clk_i), .drv_i(hdrv), .d_i(hd), .oe_i(doe),
    .q_i(dq), .bus_o(bus));
  function automatic logic [7:0] reg0(input logic pend, input logic en);
    return {pend, 6'h00, en};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // strobes end first; select and data are held a while after
  task automatic acc(input logic rd, input logic [4:0] a,
                     input logic [7:0] d);
    @(posedge clk_i);
    cs_n <= 1'b0;
    adr <= a;
    hd <= d;
    hdrv <= !rd;
    rp <= strap | !rd;
    wd <= rd;
    repeat (8) @(posedge clk_i);
    q = bus;
    chk(doe, rd ? 8'hFF : 8'h00);
    rp <= !strap;
    if (!strap) wd <= 1'b1;
    repeat (6) @(posedge clk_i);
    cs_n <= 1'b1;
    hdrv <= 1'b0;
    wd <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk(doe, 8'h00);
  endtask
  task automatic pulse;
    @(posedge clk_i);
    ev <= 1'b1;
    @(posedge clk_i);
    ev <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic run(input logic s);
    int i;
    logic [7:0] v;
    @(posedge clk_i);
    strap <= s;
    srst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk(st, 8'h00);
    for (i = 1; i < 32; i++) begin
      v = (i == 31) ? 8'hFF : 8'($urandom);
      exp_mem[i] = v;
      acc(1'b0, i[4:0], v);
    end
    chk(st, exp_mem[1]);
    for (i = 31; i > 0; i--) begin
      acc(1'b1, i[4:0], 8'h00);
      chk(q, exp_mem[i]);
    end
    acc(1'b0, 5'h00, 8'h01);
    pulse;
    chk({irq_oe, irq_n, 6'h00}, 8'h80);
    acc(1'b1, 5'h00, 8'h00);
    chk(q, reg0(1'b1, 1'b1));
    acc(1'b0, 5'h00, 8'h80);
    chk({irq_oe, irq_n, 6'h00}, 8'h00);
    pulse;
    chk({irq_oe, irq_n, 6'h00}, 8'h00);
    acc(1'b1, 5'h00, 8'h00);
    chk(q, reg0(1'b0, 1'b0));
  endtask
  task automatic end_of_test;
    if (err_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(32'h6E1E));
    run(1'b0);
    run(1'b1);
    end_of_test;
  end
  // about 3100 cycles expected; far more means a hang
  initial begin
    #1000000;
    err_count++;
    end_of_test;
  end
endmodule
